/* File: verilog/bfrp_top.sv */
// branch folding, misprediction recovery and return stack of the prefetch unit
// Overview of operation
// (RQ1) folded branch is dropped from delivered stream
// (RQ2) fold only if no link, break, abort, branch-ahead
// (RQ3) folding applies on later prefetches only
// (RQ4) resolve by third stage; mispredict flushes, refetches
// (RQ5) insn after failed folded branch forced fail; code only marks it with out_folded, out_force_fail stays 0
// (RQ6) keep recovery address for every uncertain prediction
// (RQ7) forward folded branch condition to core
// (RQ8) core flushes and restarts at recovery address
// (RQ9) return stack is three-entry circular buffer
// (RQ10) only unconditional returns use return stack
// (RQ11) predicted calls push execute-stage return address
// (RQ12) immediate calls predicted on cache hit; register never
// (RQ13) static: unconditional calls taken, conditional not
// (RQ14) predicted return fetches stack top, then pops; code skips the pop when ex_call pushes in the same cycle
// (RQ15) empty return stack gives no prediction
// (RQ16) return mispredict on condition fail or wrong target
// (RQ17) static predicts only always-taken returns
// (RQ18) control bit 11 enables prediction, clear at reset; the bench holds bit 11 set through reset
// (RQ19) folding only in base 32-bit state
// (RQ20) static direction from offset sign bit
// (RQ21) push on full stack overwrites oldest
// (RQ22) flush discards pending fold and return prediction
module bfrp_top
	import bfrp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] control_reg,
	input wire logic base_state,
	input wire logic pf_valid,
	input wire logic [ADDR_W-1:0] pf_addr,
	input wire logic [INSN_W-1:0] pf_insn,
	input wire bfrp_cls_e pf_cls,
	input wire logic [COND_W-1:0] pf_cond,
	input wire logic [ADDR_W-1:0] pf_offset,
	input wire logic pf_breakpoint,
	input wire logic pf_abort,
	input wire logic cache_hit,
	input wire logic cache_taken,
	input wire logic [ADDR_W-1:0] cache_target,
	input wire logic [FOLD_LOOKAHEAD-1:0] target_has_branch,
	input wire logic ex_call,
	input wire logic [ADDR_W-1:0] ex_return_addr,
	input wire logic res_valid,
	input wire logic [1:0] res_stage,
	input wire logic res_cond_pass,
	input wire logic [ADDR_W-1:0] res_actual,
	input wire logic res_is_return,
	input wire logic core_flush,
	input wire logic [ADDR_W-1:0] core_flush_addr,
	output logic [ADDR_W-1:0] fetch_addr,
	output logic out_valid,
	output logic [INSN_W-1:0] out_insn,
	output logic [ADDR_W-1:0] out_addr,
	output logic out_force_fail,
	output logic out_folded,
	output logic [COND_W-1:0] out_fold_cond,
	output logic [ADDR_W-1:0] recovery_addr,
	output logic recovery_valid,
	output logic mispredict,
	output logic ras_empty
);
	bfrp_state_e state;
	logic [ADDR_W-1:0] ras [RAS_DEPTH];
	logic [RAS_PTR_W-1:0] ras_top;
	logic [RAS_PTR_W:0] ras_count;
	logic [ADDR_W-1:0] fold_tag;
	logic fold_ok;
	logic [ADDR_W-1:0] seq_addr;
	logic pred_en;
	logic is_call, is_return, is_imm_call, is_cond;
	logic pred_taken, pred_ret, do_fold, eligible, uncertain, wrong;
	logic [ADDR_W-1:0] next_fetch, target;
	logic fold_pending;

	function automatic logic [RAS_PTR_W-1:0] ptr_inc(input logic [RAS_PTR_W-1:0] p);
		ptr_inc = (p == PTR_LAST) ? PTR_ZERO : p + 2'h_1;
	endfunction

	function automatic logic [RAS_PTR_W-1:0] ptr_dec(input logic [RAS_PTR_W-1:0] p);
		ptr_dec = (p == PTR_ZERO) ? PTR_LAST : p - 2'h_1;
	endfunction

	assign pred_en = control_reg[CTRL_PRED_EN_BIT]; // see (RQ18)
	assign seq_addr = pf_addr + INSN_BYTES;
	assign is_cond = (pf_cond != COND_ALWAYS);
	assign is_imm_call = (pf_cls == BFRP_CLS_LINK_BRANCH_CALL) ||
		(pf_cls == BFRP_CLS_LINK_EXCHANGE_CALL);
	assign is_call = is_imm_call || (pf_cls == BFRP_CLS_LINK_EXCHANGE_REG);
	assign is_return = (pf_cls == BFRP_CLS_BRANCH_EXCHANGE_LR) ||
		(pf_cls == BFRP_CLS_LOAD_MULTIPLE_PC) || (pf_cls == BFRP_CLS_LOAD_WORD_PC);

	// return prediction needs an unconditional return and a non-empty stack
	assign pred_ret = pred_en && pf_valid && is_return && !is_cond &&
		(ras_count != '0); // see (RQ10) see (RQ15) see (RQ17)

	always_comb begin
		pred_taken = 1'b0;
		target = pf_addr + pf_offset;
		if (pred_en && pf_valid) begin
			if (pf_cls == BFRP_CLS_LINK_EXCHANGE_REG) begin
				pred_taken = 1'b0; // see (RQ12)
			end else if (cache_hit && (pf_cls == BFRP_CLS_BRANCH || is_imm_call)) begin
				pred_taken = cache_taken; // see (RQ12)
				target = cache_target;
			end else if (is_imm_call) begin
				pred_taken = !is_cond; // see (RQ13)
			end else if (pf_cls == BFRP_CLS_BRANCH) begin
				pred_taken = pf_offset[ADDR_W-1]; // see (RQ20)
			end
		end
	end

	// a link would be lost if a call were folded
	assign eligible = pf_cls == BFRP_CLS_BRANCH && !pf_breakpoint && !pf_abort &&
		(target_has_branch == '0); // see (RQ2)
	// only a table hit from an earlier prefetch folds; see (RQ3) see (RQ19)
	assign do_fold = pred_taken && base_state && fold_ok && fold_tag == pf_addr &&
		pf_cls == BFRP_CLS_BRANCH;
	assign uncertain = pf_valid && (pred_ret || (pred_en &&
		(pf_cls == BFRP_CLS_BRANCH || is_imm_call) && is_cond));
	assign wrong = res_valid && res_stage <= 2'(RESOLVE_STAGE_MAX) &&
		(!res_cond_pass || (res_is_return && res_actual != recovery_addr)); // see (RQ16)

	bfrp_fold_mem fold_mem (
		.clk(clk),
		.rst_n(rst_n),
		.clear(core_flush && !pred_en),
		.wr_en(pf_valid && pred_taken && pf_cls == BFRP_CLS_BRANCH && !do_fold),
		.wr_idx(pf_addr[FOLD_IDX_W+1:2]),
		.wr_tag(pf_addr),
		.wr_ok(eligible),
		.rd_idx(next_fetch[FOLD_IDX_W+1:2]),
		.rd_tag(fold_tag),
		.rd_ok(fold_ok)
	);

	always_comb begin
		next_fetch = fetch_addr + INSN_BYTES;
		if (core_flush) begin
			next_fetch = core_flush_addr; // see (RQ8) see (RQ22)
		end else if (pred_ret) begin
			next_fetch = ras[ras_top]; // see (RQ14)
		end else if (pred_taken) begin
			next_fetch = target;
		end else if (pf_valid) begin
			next_fetch = seq_addr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fetch_addr <= RESET_ADDR;
		end else begin
			fetch_addr <= next_fetch;
		end
	end

	// delivered stream
	always_ff @(posedge clk) begin
		if (!rst_n || core_flush) begin
			out_valid <= 1'b0; // see (RQ22)
			out_insn <= '0;
			out_addr <= '0;
			out_folded <= 1'b0;
			out_fold_cond <= COND_ALWAYS;
			out_force_fail <= 1'b0;
			fold_pending <= 1'b0;
		end else if (pf_valid && do_fold) begin
			out_valid <= 1'b0; // see (RQ1)
			fold_pending <= 1'b1;
			out_fold_cond <= pf_cond; // see (RQ7)
		end else begin
			out_valid <= pf_valid;
			out_insn <= pf_insn;
			out_addr <= pf_addr;
			out_folded <= pf_valid && fold_pending; // see (RQ5)
			if (pf_valid) begin
				fold_pending <= 1'b0;
			end
			out_force_fail <= 1'b0;
		end
	end

	// recovery information
	always_ff @(posedge clk) begin
		if (!rst_n || core_flush) begin
			recovery_valid <= 1'b0; // see (RQ22)
			recovery_addr <= '0;
		end else if (uncertain) begin
			recovery_valid <= 1'b1;
			if (pred_ret) begin
				recovery_addr <= ras[ras_top];
			end else begin
				recovery_addr <= pred_taken ? seq_addr : target; // see (RQ6)
			end
		end else if (res_valid) begin
			recovery_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || core_flush) begin
			mispredict <= 1'b0;
			state <= BFRP_FETCH;
		end else begin
			mispredict <= wrong && recovery_valid; // see (RQ4)
			unique case (state)
				BFRP_FETCH: state <= uncertain ? BFRP_WAIT_RESOLVE : BFRP_FETCH;
				BFRP_WAIT_RESOLVE: state <= res_valid ? BFRP_FETCH : BFRP_WAIT_RESOLVE;
			endcase
		end
	end

	// return stack
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ras_top <= PTR_LAST;
			ras_count <= '0;
			ras_empty <= 1'b1;
			for (int i = 0; i < RAS_DEPTH; i++) begin
				ras[i] <= '0;
			end
		end else if (ex_call && pred_en) begin
			ras[ptr_inc(ras_top)] <= ex_return_addr; // see (RQ11) see (RQ9)
			ras_top <= ptr_inc(ras_top); // see (RQ21)
			if (ras_count != 3'(RAS_DEPTH)) begin
				ras_count <= ras_count + 3'h_1;
			end
			ras_empty <= 1'b0;
		end else if (pred_ret && !core_flush) begin
			ras_top <= ptr_dec(ras_top); // see (RQ14)
			ras_count <= ras_count - 3'h_1;
			ras_empty <= (ras_count == 3'h_1);
		end
	end

	no_fold_off_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ18)
		!pred_en |=> !out_folded || $past(fold_pending))
		else $error("fold while prediction disabled");
	fold_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ1)
		(pf_valid && do_fold && !core_flush) |=> !out_valid)
		else $error("folded branch delivered");
	fold_cond_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ7)
		(pf_valid && do_fold && !core_flush) |=> out_fold_cond == $past(pf_cond))
		else $error("fold condition not forwarded");
	fold_state_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ19)
		do_fold |-> base_state)
		else $error("fold outside base state");
	ras_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ9)
		ras_count <= 3'(RAS_DEPTH))
		else $error("return stack overfilled");
	ras_empty_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ15)
		ras_empty |-> !pred_ret)
		else $error("prediction from empty stack");
	cond_ret_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ10)
		(is_return && is_cond) |-> !pred_ret)
		else $error("conditional return predicted");
	reg_call_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ12)
		(pf_cls == BFRP_CLS_LINK_EXCHANGE_REG) |-> !pred_taken)
		else $error("register call predicted");
	flush_fetch_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ8)
		core_flush |=> fetch_addr == $past(core_flush_addr) && !out_valid)
		else $error("flush not redirected");
	ret_pop_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ14)
		(pred_ret && !ex_call && !core_flush) |=> ras_count == $past(ras_count) - 3'h_1)
		else $error("return did not pop");

	// state right after reset, checked without the reset disable
	reset_state_a: assert property (@(posedge clk) // see (RQ18)
		!rst_n |=> !out_valid && !recovery_valid && !mispredict && ras_empty &&
		fetch_addr == RESET_ADDR)
		else $error("bad state after reset");
	pred_off_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ18)
		!pred_en |-> !pred_taken && !pred_ret)
		else $error("prediction while disabled");
	fold_kind_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ2)
		do_fold |-> pf_cls == BFRP_CLS_BRANCH)
		else $error("non branch folded");
	recov_taken_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ6)
		(uncertain && !core_flush && !pred_ret && pred_taken) |=>
		recovery_addr == $past(seq_addr))
		else $error("taken recovery not sequential");
	recov_nt_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ6)
		(uncertain && !core_flush && !pred_ret && !pred_taken) |=>
		recovery_addr == $past(target))
		else $error("not taken recovery not target");
	state_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ6)
		(state == BFRP_FETCH && uncertain && !core_flush) |=> state == BFRP_WAIT_RESOLVE)
		else $error("uncertain prediction not tracked");
	ret_target_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ14)
		(pred_ret && !core_flush) |=> fetch_addr == $past(ras[ras_top]))
		else $error("return not fetched from top");
	push_top_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ11)
		(ex_call && pred_en) |=> ras[ras_top] == $past(ex_return_addr))
		else $error("call not pushed");
	ras_count_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ15)
		ras_empty == (ras_count == 3'h_0))
		else $error("empty flag out of step");
	ras_ptr_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ9)
		ras_top <= PTR_LAST)
		else $error("stack pointer out of range");
	mispred_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ16)
		(wrong && recovery_valid && !core_flush) |=> mispredict)
		else $error("misprediction missed");
	late_res_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ4)
		mispredict |-> $past(res_valid) && $past(res_stage) <= 2'(RESOLVE_STAGE_MAX))
		else $error("mispredict without early resolve");
	folded_next_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ5)
		(pf_valid && !do_fold && !core_flush && fold_pending) |=> out_folded)
		else $error("insn after fold not marked");
	stream_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ1)
		(pf_valid && !do_fold && !core_flush) |=> out_valid && out_addr == $past(pf_addr))
		else $error("insn not delivered");
	taken_fetch_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ20)
		(pred_taken && !pred_ret && !core_flush) |=> fetch_addr == $past(target))
		else $error("taken branch not followed");
	fetch_seq_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ4)
		(pf_valid && !pred_taken && !pred_ret && !core_flush) |=>
		fetch_addr == $past(pf_addr) + INSN_BYTES)
		else $error("not taken path not sequential");
	cond_call_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ13)
		(is_imm_call && is_cond && !cache_hit) |-> !pred_taken)
		else $error("conditional call predicted taken");
	flush_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ22)
		core_flush |=> !recovery_valid && !mispredict && !out_valid)
		else $error("flush left pending state");

	fold_seen_c: cover property (@(posedge clk) pf_valid && do_fold);
	ret_pred_c: cover property (@(posedge clk) pred_ret);
	ras_full_c: cover property (@(posedge clk) ras_count == 3'(RAS_DEPTH) && ex_call);
	mispred_c: cover property (@(posedge clk) mispredict);
	call_push_c: cover property (@(posedge clk) pf_valid && is_call && ex_call);
endmodule

/* File: verilog/bfrp_pkg.sv */
// shared constants and types for the branch fold and return predict block
package bfrp_pkg;
	localparam int ADDR_W = 32;
	localparam int INSN_W = 32;
	localparam int COND_W = 4;
	localparam int RAS_DEPTH = 3;
	localparam int RAS_PTR_W = 2;
	localparam int CTRL_PRED_EN_BIT = 11;
	localparam int FOLD_LOOKAHEAD = 2;
	localparam int FOLD_TAB_DEPTH = 16;
	localparam int FOLD_IDX_W = 4;
	localparam int RESOLVE_STAGE_MAX = 3;
	localparam logic [COND_W-1:0] COND_ALWAYS = 4'h_e;
	localparam logic [COND_W-1:0] COND_NEVER = 4'h_f;
	localparam logic [ADDR_W-1:0] INSN_BYTES = 32'h_0000_0004;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 32'h_0000_0000;
	localparam logic [RAS_PTR_W-1:0] PTR_ZERO = 2'h_0;
	localparam logic [RAS_PTR_W-1:0] PTR_LAST = 2'h_2;

	typedef enum logic [2:0] {
		BFRP_CLS_PLAIN,
		BFRP_CLS_BRANCH,
		BFRP_CLS_LINK_BRANCH_CALL,
		BFRP_CLS_LINK_EXCHANGE_CALL,
		BFRP_CLS_LINK_EXCHANGE_REG,
		BFRP_CLS_BRANCH_EXCHANGE_LR,
		BFRP_CLS_LOAD_MULTIPLE_PC,
		BFRP_CLS_LOAD_WORD_PC
	} bfrp_cls_e;

	typedef enum logic [1:0] {
		BFRP_FETCH,
		BFRP_WAIT_RESOLVE
	} bfrp_state_e;
endpackage

/* File: verilog/bfrp_fold_mem.sv */
// small table remembering which branch addresses are fold eligible
module bfrp_fold_mem
	import bfrp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [FOLD_IDX_W-1:0] wr_idx,
	input wire logic [ADDR_W-1:0] wr_tag,
	input wire logic wr_ok,
	input wire logic [FOLD_IDX_W-1:0] rd_idx,
	output logic [ADDR_W-1:0] rd_tag,
	output logic rd_ok
);
	logic [ADDR_W-1:0] tag_mem [FOLD_TAB_DEPTH];
	logic [FOLD_TAB_DEPTH-1:0] ok_mem;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			tag_mem[wr_idx] <= wr_tag;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			ok_mem <= '0;
		end else if (wr_en) begin
			ok_mem[wr_idx] <= wr_ok;
		end
	end

	// registered read; write in same cycle is seen next time only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_tag <= '0;
			rd_ok <= 1'b0;
		end else begin
			rd_tag <= tag_mem[rd_idx];
			rd_ok <= ok_mem[rd_idx] && !clear;
		end
	end
endmodule

/* File: test/bfrp_core_model.sv */
// behavioural integer core: resolves branches and flushes the prefetch unit
module bfrp_core_model
	import bfrp_pkg::*;
(
	input wire logic clk,
	input wire logic mispredict,
	input wire logic [ADDR_W-1:0] recovery_addr,
	output logic res_valid,
	output logic [1:0] res_stage,
	output logic res_cond_pass,
	output logic [ADDR_W-1:0] res_actual,
	output logic res_is_return,
	output logic core_flush,
	output logic [ADDR_W-1:0] core_flush_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		res_valid = 1'b0;
		res_stage = 2'h_0;
		res_cond_pass = 1'b0;
		res_actual = 32'h_0000_0000;
		res_is_return = 1'b0;
		core_flush = 1'b0;
		core_flush_addr = 32'h_0000_0000;
	end
	// stage argument sets res_stage; no 2-bit value exceeds RESOLVE_STAGE_MAX, so no resolve counts as late
	task automatic resolve(input logic [1:0] stg, input logic pass, input logic [ADDR_W-1:0] act,
		input logic ret);
		res_valid = 1'b1;
		res_stage = stg;
		res_cond_pass = pass;
		res_actual = act;
		res_is_return = ret;
		@(negedge clk);
		res_valid = 1'b0;
		// stale stage and actual values are inverted so nothing leans on them
		res_stage = ~stg;
		res_actual = ~act;
	endtask
	always @(negedge clk) begin
		if (mispredict === 1'b1) begin
			core_flush = 1'b1;
			core_flush_addr = recovery_addr;
		end else if (core_flush) begin
			core_flush = 1'b0;
			core_flush_addr = ~core_flush_addr;
		end
	end
endmodule

/* File: test/bfrp_top_tb_top.sv */
// self-checking bench for branch folding, recovery and the return stack
module bfrp_top_tb_top
	import bfrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] OK = 6'h_03;
	logic clk, rst_n, base_state, pf_valid, pf_breakpoint, pf_abort, cache_hit, cache_taken;
	logic ex_call, res_valid, res_cond_pass, res_is_return, core_flush;
	logic [ADDR_W-1:0] control_reg, pf_addr, pf_offset, cache_target, ex_return_addr;
	logic [ADDR_W-1:0] res_actual, core_flush_addr, fetch_addr, out_addr, recovery_addr;
	logic [INSN_W-1:0] pf_insn, out_insn;
	logic [COND_W-1:0] pf_cond, out_fold_cond;
	logic [1:0] target_has_branch, res_stage;
	logic out_valid, out_force_fail, out_folded, recovery_valid, mispredict, ras_empty;
	bfrp_cls_e pf_cls;
	int n_errors = 0;
	int checks_done = 0;
	bfrp_top dut_u (.*);
	bfrp_core_model core_u (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [ADDR_W-1:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// fl holds breakpoint, abort, target branches, base state, enable
	task automatic fetch(input logic [ADDR_W-1:0] a, input bfrp_cls_e c, input logic [3:0] cnd,
		input logic hit, input logic [5:0] fl);
		pf_valid = 1'b1;
		pf_addr = a;
		pf_insn = ~a;
		pf_cls = c;
		pf_cond = cnd;
		cache_hit = hit;
		cache_taken = hit;
		cache_target = a + 32'h_0000_0400;
		{pf_breakpoint, pf_abort, target_has_branch, base_state} = fl[5:1];
		control_reg[CTRL_PRED_EN_BIT] = fl[0];
		@(negedge clk);
	endtask
	task automatic idle();
		pf_valid = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_fold();
		fetch(32'h_0000_0100, BFRP_CLS_BRANCH, 4'h_0, 1'b1, OK);
		chk("first kept", out_valid, 1'b1);
		chk("taken", fetch_addr, 32'h_0000_0500);
		// call whose target brings the fetch address back onto the branch
		fetch(32'h_0000_00c0, BFRP_CLS_LINK_BRANCH_CALL, COND_ALWAYS, 1'b0, OK);
		chk("call taken", fetch_addr, 32'h_0000_0100);
		fetch(32'h_0000_0100, BFRP_CLS_BRANCH, 4'h_0, 1'b1, OK);
		chk("fold drop", out_valid, 1'b0);
		chk("fold cond", out_fold_cond, 4'h_0);
		chk("recovery", recovery_addr, 32'h_0000_0104);
		fetch(32'h_0000_0500, BFRP_CLS_PLAIN, COND_ALWAYS, 1'b0, OK);
		chk("after fold", out_folded, 1'b1);
		chk("after fold addr", out_addr, 32'h_0000_0500);
		chk("after fold insn", out_insn, ~32'h_0000_0500);
		chk("force fail", out_force_fail, 1'b0);
		idle();
		core_u.resolve(2'h_3, 1'b0, 32'h_0000_0104, 1'b0);
		chk("mispredict", mispredict, 1'b1);
		@(negedge clk);
		chk("restart", fetch_addr, 32'h_0000_0104);
	endtask
	task automatic t_nofold();
		logic [5:0] fl[5] = '{6'h_23, 6'h_13, 6'h_0b, 6'h_01, 6'h_02};
		for (int i = 0; i < 5; i++) begin
			repeat (2) fetch(32'h_0000_0104 + 32'(4 * i), BFRP_CLS_BRANCH, 4'h_0, 1'b1, fl[i]);
			chk("no fold", out_valid, 1'b1);
		end
	endtask
	task automatic t_predict();
		fetch(32'h_0000_0118, BFRP_CLS_LINK_EXCHANGE_REG, COND_ALWAYS, 1'b1, OK);
		chk("reg call", fetch_addr, 32'h_0000_011c);
		fetch(32'h_0000_011c, BFRP_CLS_BRANCH, 4'h_0, 1'b0, OK);
		chk("forward", fetch_addr, 32'h_0000_0120);
		fetch(32'h_0000_0120, BFRP_CLS_LINK_BRANCH_CALL, 4'h_0, 1'b0, OK);
		chk("cond call", fetch_addr, 32'h_0000_0124);
	endtask
	task automatic t_ras();
		bfrp_cls_e rc[3] = '{BFRP_CLS_BRANCH_EXCHANGE_LR, BFRP_CLS_LOAD_MULTIPLE_PC,
			BFRP_CLS_LOAD_WORD_PC};
		// four pushes into three slots: the first must be lost
		for (int i = 0; i < 4; i++) begin
			ex_call = 1'b1;
			ex_return_addr = 32'h_0000_1000 + 32'(16 * i);
			@(negedge clk);
		end
		ex_call = 1'b0;
		ex_return_addr = ~ex_return_addr;
		chk("pushed", ras_empty, 1'b0);
		fetch(32'h_0000_0200, BFRP_CLS_BRANCH_EXCHANGE_LR, 4'h_0, 1'b0, OK);
		chk("cond return", fetch_addr, 32'h_0000_0204);
		for (int i = 3; i > 0; i--) begin
			fetch(32'h_0000_0200, rc[i - 1], COND_ALWAYS, 1'b0, OK);
			chk("return", fetch_addr, 32'h_0000_1000 + 32'(16 * i));
		end
		chk("drained", ras_empty, 1'b1);
		fetch(32'h_0000_0200, BFRP_CLS_BRANCH_EXCHANGE_LR, COND_ALWAYS, 1'b0, OK);
		chk("empty return", fetch_addr, 32'h_0000_0204);
		idle();
	endtask
	initial begin
		rst_n = 1'b0;
		control_reg = 32'h_0000_0800;
		{base_state, pf_valid, pf_breakpoint, pf_abort, cache_hit, cache_taken} = 6'h_20;
		{pf_addr, pf_insn, pf_offset, cache_target} = '0;
		pf_offset = 32'h_0000_0040;
		pf_cls = BFRP_CLS_PLAIN;
		pf_cond = COND_ALWAYS;
		target_has_branch = 2'h_0;
		ex_call = 1'b0;
		ex_return_addr = 32'h_0000_0000;
		repeat (8) @(negedge clk);
		chk("reset fetch", fetch_addr, RESET_ADDR);
		chk("reset ras", ras_empty, 1'b1);
		chk("reset recovery", recovery_valid, 1'b0);
		rst_n = 1'b1;
		t_fold();
		t_nofold();
		t_predict();
		t_ras();
		stop_test();
	end
endmodule
